// file: shared/flash_ctl_map.vh
`ifndef FLASH_CTL_MAP_VH
`define FLASH_CTL_MAP_VH
// ********************************************************************
// software register map of the controller (word index on its port)
// ********************************************************************
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_ARG 4'h2
`define REG_STAT 4'h3
`define REG_RDATA 4'h4
`define REG_PULSES 4'h5
// ctrl register: write launches a command
`define CMD_CFG 3'h1
`define CMD_LOCK 3'h2
`define CMD_UNLOCK_ALL 3'h3
`define CMD_QUERY 3'h4
`define CMD_CLRSTAT 3'h5
`define CMD_RDSTAT 3'h6
// ********************************************************************
// flash command codes
// ********************************************************************
`define FC_CFG_SETUP 16'h00B8
`define FC_LOCK_SETUP 16'h0060
`define FC_LOCK_SET 16'h0001
`define FC_LOCK_CLEAR 16'h00D0
`define FC_READ_INFO 16'h0090
`define FC_CLEAR_STATUS 16'h0050
`define FC_READ_STATUS 16'h0070
`define FC_READ_ARRAY 16'h00FF
`define LOCK_OFFSET 24'h000002
`define CFG_MASK 8'h03
// status register bits of the device
`define SR_READY 7
`define SR_ERASE_ERR 5
`define SR_PROG_ERR 4
// bus timing in clocks of 50 ns
`define T_WE_CYC 4'h2
`define T_RD_CYC 4'h3
`define BUSY_TIMEOUT 24'hFFFFFF
`endif

// file: design/flash_ctl.v
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "flash_ctl_map.vh"

// Summary of operation
// - config is write 00B8h then the config code, any address
// - host issues config only when ready bit shows idle
// - code bits 7 to 2 are reserved; host sends them zero
// - lock one block: 0060h then 0001h inside the block
// - unlock all: 0060h then 00D0h at any address
// - no lock commands while busy or suspended
// - set failures in one error bit, clear in another
// - lock state is data bit zero at block base plus 02h
module flash_ctl #(
    parameter AW = 24,
    parameter TIMEOUT = 24'hFFFFFF
) (
    input wire clk,
    input wire srst,
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdata,
    output reg [AW-1:0] flashAddr,
    output reg [15:0] flashDqOut,
    output reg flashDqOe,
    input wire [15:0] flashDqIn,
    output reg flashCeN,
    output reg flashOeN,
    output reg flashWeN,
    output reg hwResetPinN,
    input wire statusPin
);
    // ****************************************************************
    // states
    // ****************************************************************
    localparam S_IDLE = 4'h0;
    localparam S_WR1 = 4'h1;
    localparam S_WR2 = 4'h2;
    localparam S_POLL = 4'h3;
    localparam S_RD = 4'h4;
    localparam S_DONE = 4'h5;
    localparam S_RST = 4'h6;

    reg [3:0] state_reg;
    reg [2:0] cmd_reg;
    reg [AW-1:0] addr_reg;
    reg [7:0] arg_reg;
    reg [15:0] rdata_reg;
    reg [7:0] devStat_reg;
    reg busy_reg;
    reg refused_reg;
    reg timeout_reg;
    reg [1:0] pinMode_reg;
    reg [15:0] pulses_reg;
    reg [1:0] step_reg;
    reg [3:0] tmr_reg;
    reg [23:0] wait_reg;
    reg pinS1_reg;
    reg pinS2_reg;
    reg pinOld_reg;
    reg [15:0] wbuf_reg;

    // first command word of each sequence
    function [15:0] firstWord;
        input [2:0] c;
        begin
            case (c)
                `CMD_CFG: firstWord = `FC_CFG_SETUP;
                `CMD_LOCK: firstWord = `FC_LOCK_SETUP;
                `CMD_UNLOCK_ALL: firstWord = `FC_LOCK_SETUP;
                `CMD_QUERY: firstWord = `FC_READ_INFO;
                `CMD_CLRSTAT: firstWord = `FC_CLEAR_STATUS;
                default: firstWord = `FC_READ_STATUS;
            endcase
        end
    endfunction

    // confirm word; code 00h still goes out as a real write
    function [15:0] secondWord;
        input [2:0] c;
        input [7:0] a;
        begin
            case (c)
                `CMD_CFG: secondWord = {8'h00, a & `CFG_MASK};
                `CMD_LOCK: secondWord = `FC_LOCK_SET;
                `CMD_UNLOCK_ALL: secondWord = `FC_LOCK_CLEAR;
                default: secondWord = 16'h0000;
            endcase
        end
    endfunction

    // sequences that need a confirm write after the setup word
    function twoWord;
        input [2:0] c;
        begin
            case (c)
                `CMD_CFG: twoWord = 1'b1;
                `CMD_LOCK: twoWord = 1'b1;
                `CMD_UNLOCK_ALL: twoWord = 1'b1;
                default: twoWord = 1'b0;
            endcase
        end
    endfunction

    // ****************************************************************
    // status pin synchroniser; pulses counted on rising edge
    // ****************************************************************
    always @(posedge clk) begin
        if (srst) begin
            pinS1_reg <= 1'b1;
            pinS2_reg <= 1'b1;
            pinOld_reg <= 1'b1;
            pulses_reg <= 16'h0000;
        end else begin
            pinS1_reg <= statusPin;
            pinS2_reg <= pinS1_reg;
            pinOld_reg <= pinS2_reg;
            // a 500 ns low spans ten clocks, easily caught
            if (pinMode_reg != 2'b00 && pinS2_reg && !pinOld_reg)
                pulses_reg <= pulses_reg + 16'h0001;
        end
    end

    // ****************************************************************
    // register read port, data one cycle after the strobe
    // ****************************************************************
    always @(posedge clk) begin
        if (srst) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `REG_ADDR: regRdata <= addr_reg[15:0];
                `REG_ARG: regRdata <= {8'h00, arg_reg};
                `REG_STAT: regRdata <= {pinMode_reg, timeout_reg,
                    refused_reg, pinS2_reg, cmd_reg, devStat_reg[7:1],
                    busy_reg};
                `REG_RDATA: regRdata <= rdata_reg;
                `REG_PULSES: regRdata <= pulses_reg;
                default: regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

    // ****************************************************************
    // sequencer driving the parallel bus
    // ****************************************************************
    always @(posedge clk) begin
        if (srst) begin
            state_reg <= S_RST;
            cmd_reg <= 3'h0;
            addr_reg <= {AW{1'b0}};
            arg_reg <= 8'h00;
            rdata_reg <= 16'h0000;
            devStat_reg <= 8'h00;
            busy_reg <= 1'b1;
            refused_reg <= 1'b0;
            timeout_reg <= 1'b0;
            pinMode_reg <= 2'b00;
            step_reg <= 2'b00;
            tmr_reg <= 4'h0;
            wait_reg <= 24'h000000;
            wbuf_reg <= 16'h0000;
            flashAddr <= {AW{1'b0}};
            flashDqOut <= 16'h0000;
            flashDqOe <= 1'b0;
            flashCeN <= 1'b1;
            flashOeN <= 1'b1;
            flashWeN <= 1'b1;
            hwResetPinN <= 1'b0;
        end else begin
            if (regWr && regAddr == `REG_ADDR)
                addr_reg <= {{(AW-16){1'b0}}, regWdata};
            if (regWr && regAddr == `REG_ARG)
                arg_reg <= regWdata[7:0];
            case (state_reg)
                S_RST: begin
                    // device pin mode returns to level on reset
                    hwResetPinN <= 1'b1;
                    pinMode_reg <= 2'b00;
                    busy_reg <= 1'b0;
                    state_reg <= S_IDLE;
                end
                S_IDLE: begin
                    if (regWr && regAddr == `REG_CTRL) begin
                        refused_reg <= 1'b0;
                        timeout_reg <= 1'b0;
                        cmd_reg <= regWdata[2:0];
                        if (twoWord(regWdata[2:0]) &&
                            (!devStat_reg[`SR_READY] ||
                            (regWdata[2:0] == `CMD_CFG &&
                            arg_reg[1:0] == 2'b10))) begin
                            // idle must be known first; 10 not sent
                            refused_reg <= 1'b1;
                        end else begin
                            busy_reg <= 1'b1;
                            wbuf_reg <= firstWord(regWdata[2:0]);
                            step_reg <= 2'b00;
                            state_reg <= S_WR1;
                        end
                    end
                end
                S_WR1: begin
                    // one write pulse of T_WE_CYC plus one clocks
                    flashAddr <= (cmd_reg == `CMD_LOCK) ? addr_reg :
                        {AW{1'b0}};
                    flashDqOut <= wbuf_reg;
                    flashDqOe <= 1'b1;
                    flashCeN <= 1'b0;
                    flashWeN <= 1'b0;
                    tmr_reg <= `T_WE_CYC;
                    state_reg <= S_WR2;
                end
                S_WR2: begin
                    if (tmr_reg != 4'h0) begin
                        tmr_reg <= tmr_reg - 4'h1;
                    end else begin
                        flashWeN <= 1'b1;
                        flashCeN <= 1'b1;
                        flashDqOe <= 1'b0;
                        if (step_reg == 2'b00 && twoWord(cmd_reg)) begin
                            wbuf_reg <= secondWord(cmd_reg, arg_reg);
                            step_reg <= 2'b01;
                            state_reg <= S_WR1;
                        end else begin
                            if (cmd_reg == `CMD_CFG)
                                pinMode_reg <= arg_reg[1:0];
                            step_reg <= 2'b10;
                            wait_reg <= TIMEOUT;
                            state_reg <= S_RD;
                        end
                    end
                end
                S_RD: begin
                    // status read after lock setup, info read for query
                    flashAddr <= (cmd_reg == `CMD_QUERY) ?
                        addr_reg + `LOCK_OFFSET : {AW{1'b0}};
                    flashCeN <= 1'b0;
                    flashOeN <= 1'b0;
                    tmr_reg <= `T_RD_CYC;
                    state_reg <= S_POLL;
                end
                S_POLL: begin
                    if (tmr_reg != 4'h0) begin
                        tmr_reg <= tmr_reg - 4'h1;
                    end else begin
                        flashCeN <= 1'b1;
                        flashOeN <= 1'b1;
                        rdata_reg <= flashDqIn;
                        if (cmd_reg == `CMD_QUERY) begin
                            rdata_reg <= {15'h0000, flashDqIn[0]};
                            state_reg <= S_DONE;
                        end else if (flashDqIn[`SR_READY]) begin
                            // ready bit high ends the operation
                            devStat_reg <= flashDqIn[7:0];
                            state_reg <= S_DONE;
                        end else if (wait_reg == 24'h000000) begin
                            timeout_reg <= 1'b1;
                            state_reg <= S_DONE;
                        end else begin
                            wait_reg <= wait_reg - 24'h000001;
                            state_reg <= S_RD;
                        end
                    end
                end
                S_DONE: begin
                    // error bits show refused lock or bad config code
                    if (cmd_reg == `CMD_CFG &&
                        (devStat_reg[`SR_PROG_ERR] ||
                        devStat_reg[`SR_ERASE_ERR]))
                        refused_reg <= 1'b1;
                    if (cmd_reg == `CMD_LOCK && devStat_reg[`SR_PROG_ERR])
                        refused_reg <= 1'b1;
                    if (cmd_reg == `CMD_UNLOCK_ALL &&
                        devStat_reg[`SR_ERASE_ERR])
                        refused_reg <= 1'b1;
                    busy_reg <= 1'b0;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // flash_ctl

// file: verification/flash_ctl_chk.sv
`timescale 1ns/1ps
// ****************************************
// bus strobe checks on the controller pins
// ****************************************
module flash_ctl_chk #(
    parameter AW = 24
) (
    input wire clk,
    input wire srst,
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [15:0] regRdata,
    input wire [AW-1:0] flashAddr,
    input wire [15:0] flashDqOut,
    input wire flashDqOe,
    input wire [15:0] flashDqIn,
    input wire flashCeN,
    input wire flashOeN,
    input wire flashWeN,
    input wire hwResetPinN,
    input wire statusPin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_we_needs_ce: assert property (!flashWeN |-> !flashCeN)
        else $error("write strobe without chip select");
    a_oe_needs_ce: assert property (!flashOeN |-> !flashCeN)
        else $error("read strobe without chip select");
    a_strobe_excl: assert property (!(!flashOeN && !flashWeN))
        else $error("read and write strobes together");
    a_write_drives: assert property (!flashWeN |-> flashDqOe)
        else $error("write cycle with data bus released");
    a_read_released: assert property (!flashOeN |-> !flashDqOe)
        else $error("bus driven during a read");
    a_write_width: assert property ($fell(flashWeN) |->
        !flashWeN ##1 !flashWeN ##[1:3] flashWeN)
        else $error("write strobe width off");
    a_read_width: assert property ($fell(flashOeN) |-> (!flashOeN)[*3])
        else $error("read strobe too short");
    a_write_hold: assert property (!flashWeN && !$past(flashWeN) |->
        $stable(flashDqOut) && $stable(flashAddr))
        else $error("write data moved while strobe low");
    a_reset_idle: assert property ($fell(srst) |-> flashCeN &&
        flashWeN && flashOeN && !flashDqOe && !hwResetPinN)
        else $error("pins not idle out of reset");
    a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
        else $error("read data outside its cycle");
    c_write: cover property ($fell(flashWeN));
    c_read: cover property ($fell(flashOeN));
    c_lock_seen: cover property (regRd ##1 regRdata[0]);
endmodule // flash_ctl_chk

bind flash_ctl flash_ctl_chk #(.AW(AW)) u_flash_ctl_chk (.clk(clk),
    .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn),
    .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .hwResetPinN(hwResetPinN), .statusPin(statusPin));

// file: verification/flash_dev_model.sv
`timescale 1ns/1ps
// ****************************************
// behavioural flash device, clockless
// ****************************************
module flash_dev_model #(
    parameter BUSY_NS = 700,
    parameter BLK_SHIFT = 4
) (
    input wire [23:0] flashAddr,
    input wire [15:0] flashDqOut,
    input wire flashCeN,
    input wire flashOeN,
    input wire flashWeN,
    input wire hwResetPinN,
    input wire supplyLow,
    input wire opDone,
    output wire [15:0] flashDqIn,
    output wire statusPin
);
    reg [255:0] lockBits = 256'h0;
    reg [7:0] sr = 8'h80;
    reg [1:0] pinCfg = 2'h0;
    reg [1:0] pend = 2'h0;
    reg [1:0] rdMode = 2'h0;
    reg [15:0] lastOut = 16'h0;
    reg [23:0] wa = 24'h0;
    reg [15:0] wd = 16'h0;
    reg wSel = 1'b0;
    reg pulseLow = 1'b0;
    wire [7:0] blk = wa[BLK_SHIFT+7:BLK_SHIFT];
    wire [7:0] rblk = flashAddr[BLK_SHIFT+7:BLK_SHIFT];
    wire infoHit = flashAddr[BLK_SHIFT-1:0] == 2;
    wire [15:0] readVal = (rdMode == 2'h1) ? {8'h00, sr} :
        (rdMode == 2'h2) ? {15'h0, infoHit & lockBits[rblk]} : 16'hFFFF;
    // bus is not pulled: released reads show the inverse of the last word
    assign flashDqIn = (!flashCeN && !flashOeN) ? readVal : ~lastOut;
    // no pulses exist for lock work, so pulse modes idle high
    assign statusPin = (pinCfg == 2'h0) ? sr[7] : !pulseLow;
    // stands in for an array operation finishing: one low pulse
    always @(posedge opDone) begin
        pulseLow = 1'b1;
        #500 pulseLow = 1'b0;
    end
    always @(posedge flashOeN) lastOut = readVal;
    // lock bits survive the reset pin
    always @(negedge hwResetPinN) begin
        pinCfg = 2'h0;
        pend = 2'h0;
        rdMode = 2'h0;
    end
    // data is latched after the fall, since pins change on the same edge
    always @(negedge flashWeN) begin
        #1 wa = flashAddr;
        wd = flashDqOut;
        wSel = !flashCeN;
    end
    // select taken at the fall: chip select rises on the same edge
    always @(posedge flashWeN) if (wSel && hwResetPinN) begin
        if (pend == 2'h1) begin
            pend = 2'h0;
            if (wd[1:0] == 2'h2) sr[5:4] = 2'h3;
            else pinCfg = wd[1:0];
        end else if (pend == 2'h2) begin
            pend = 2'h0;
            sr[7] = 1'b0;
            #(BUSY_NS);
            if (wd == 16'h0001 && supplyLow) sr[4] = 1'b1;
            else if (wd == 16'h0001) lockBits[blk] = 1'b1;
            else if (supplyLow) sr[5] = 1'b1;
            else lockBits = 256'h0;
            sr[7] = 1'b1;
        end else if (wd == 16'h00B8) pend = 2'h1;
        else if (wd == 16'h0060) begin
            pend = 2'h2;
            rdMode = 2'h1;
        end else if (wd == 16'h0090) rdMode = 2'h2;
        else if (wd == 16'h0070) rdMode = 2'h1;
        else if (wd == 16'h0050) sr[5:4] = 2'h0;
        else rdMode = 2'h0;
    end
endmodule // flash_dev_model

// file: verification/flash_ctl_tb.sv
`timescale 1ns/1ps
`include "flash_ctl_map.vh"
// ****************************************
// controller bench with device model
// ****************************************
module flash_ctl_tb;
    reg clk, srst, regWr, regRd, supplyLow, opDone;
    reg [3:0] regAddr;
    reg [15:0] regWdata, stat, rdv;
    wire [15:0] regRdata, flashDqOut, flashDqIn;
    wire [23:0] flashAddr;
    wire flashDqOe, flashCeN, flashOeN, flashWeN, hwResetPinN, statusPin;
    integer error_cnt = 0, tests_run = 0, cyc = 0, i;
    reg [39:0] cfgTab = 40'h03_01_FF_02_00; // leftmost code sent first
    reg [9:0] modeTab = {2'h3, 2'h1, 2'h3, 2'h3, 2'h0};
    reg [4:0] refTab = 5'b00010;
    flash_ctl #(.TIMEOUT(24'd20)) u_flash_ctl (.clk(clk), .srst(srst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
        .flashDqOe(flashDqOe), .flashDqIn(flashDqIn), .flashCeN(flashCeN),
        .flashOeN(flashOeN), .flashWeN(flashWeN), .hwResetPinN(hwResetPinN),
        .statusPin(statusPin));
    flash_dev_model u_flash_dev_model (.flashAddr(flashAddr),
        .flashDqOut(flashDqOut), .flashCeN(flashCeN), .flashOeN(flashOeN),
        .flashWeN(flashWeN), .hwResetPinN(hwResetPinN),
        .supplyLow(supplyLow), .opDone(opDone), .flashDqIn(flashDqIn),
        .statusPin(statusPin));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard, well above the several hundred cycles the run needs
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
        end
    end
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // an idle edge after each strobe keeps one assignment per time step
    task wr(input [3:0] a, input [15:0] d);
        begin
            regAddr <= a;
            regWdata <= d;
            regWr <= 1'b1;
            @(posedge clk);
            regWr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [3:0] a, output [15:0] d);
        begin
            regAddr <= a;
            regRd <= 1'b1;
            @(posedge clk);
            regRd <= 1'b0;
            @(posedge clk);
            d = regRdata;
        end
    endtask
    task chk(input [8*8-1:0] nm, input [15:0] exp, input [15:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task run(input [2:0] c, input [15:0] arg);
        integer n;
        begin
            wr(`REG_ARG, arg);
            wr(`REG_CTRL, {13'h0, c});
            n = 0;
            rd(`REG_STAT, stat);
            while (stat[0] !== 1'b0 && n < 500) begin
                rd(`REG_STAT, stat);
                n = n + 1;
            end
            chk("busy", 16'h0000, {15'h0, stat[0]});
        end
    endtask
    task query(input [15:0] a, input exp);
        begin
            wr(`REG_ADDR, a);
            run(`CMD_QUERY, 16'h0000);
            rd(`REG_RDATA, rdv);
            chk("lockbit", {15'h0, exp}, rdv);
        end
    endtask
    task do_reset;
        begin
            srst <= 1'b1;
            repeat (3) @(posedge clk);
            srst <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    initial begin
        srst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        supplyLow = 1'b0;
        opDone = 1'b0;
        do_reset;
        run(`CMD_CFG, 16'h0003);
        chk("refused", 16'h1000, stat & 16'hD000);
        run(`CMD_RDSTAT, 16'h0000);
        chk("ready", 16'h0080, stat & 16'h00B0);
        // every code, a reserved-bit code and the unsupported one
        for (i = 4; i >= 0; i = i - 1) begin
            run(`CMD_CFG, {8'h00, cfgTab[i*8+:8]});
            chk("pinmode", {modeTab[i*2+:2], 1'b0, refTab[i], 12'h0},
                stat & 16'hD000);
        end
        run(`CMD_CFG, 16'h0003);
        wr(`REG_ADDR, 16'h0010);
        run(`CMD_LOCK, 16'h0000);
        chk("lockstat", 16'h0080, stat & 16'h00B0);
        rd(`REG_PULSES, rdv);
        chk("pulses", 16'h0000, rdv);
        opDone <= 1'b1;
        repeat (20) @(posedge clk);
        rd(`REG_PULSES, rdv);
        chk("pulses", 16'h0001, rdv);
        query(16'h0010, 1'b1);
        query(16'h0020, 1'b0);
        run(`CMD_UNLOCK_ALL, 16'h0000);
        query(16'h0010, 1'b0);
        wr(`REG_ADDR, 16'h0020);
        run(`CMD_LOCK, 16'h0000);
        do_reset;
        rd(`REG_STAT, stat);
        chk("rstmode", 16'h0000, stat & 16'hC000);
        run(`CMD_RDSTAT, 16'h0000);
        query(16'h0020, 1'b1);
        supplyLow <= 1'b1;
        wr(`REG_ADDR, 16'h0010);
        run(`CMD_LOCK, 16'h0000);
        chk("lockerr", 16'h0090, stat & 16'h00B0);
        query(16'h0010, 1'b0);
        run(`CMD_UNLOCK_ALL, 16'h0000);
        chk("unlkerr", 16'h00B0, stat & 16'h00B0);
        query(16'h0020, 1'b1);
        run(`CMD_CLRSTAT, 16'h0000);
        run(`CMD_RDSTAT, 16'h0000);
        chk("clrerr", 16'h0080, stat & 16'h00B0);
        report_and_stop;
    end
endmodule // flash_ctl_tb
